// ---- verilog/mmd_map.svh ----
`ifndef MMD_MAP_SVH
`define MMD_MAP_SVH

// message kinds (upper status nibble)
`define MMD_KIND_CTRL      4'hB
`define MMD_KIND_PROG      4'hC
`define MMD_KIND_CHPRESS   4'hD

// system bytes
`define MMD_SX_START       8'hF0
`define MMD_SX_END         8'hF7
`define MMD_RT_MIN         8'hF8
`define MMD_RT_RESET       8'hFF
`define MMD_NO_STATUS      8'h00

// controller numbers
`define MMD_CC_DATA        7'h06
`define MMD_CC_RPN_LSB     7'h64
`define MMD_CC_RPN_MSB     7'h65
`define MMD_CC_LOCAL       7'h7A
`define MMD_CC_NOTES_OFF   7'h7B

// registered parameter selections
`define MMD_RPN_MSB_VAL    7'h00
`define MMD_RPN_BEND       7'h00
`define MMD_RPN_FINE       7'h01
`define MMD_RPN_COARSE     7'h02
`define MMD_RPN_NULL       7'h7F

// values written by the block
`define MMD_DETUNE_NORMAL  7'h00
`define MMD_ZERO7          7'h00
`define MMD_LAST_LAYER     2'h3
`define MMD_GM_BANK        3'h3

// sizes
`define MMD_CHANNELS       16
`define MMD_FIFO_DEPTH     8
`define MMD_BYTE_W         8

// transmit sequencing
`define MMD_TX_IDLE        2'h0
`define MMD_TX_STAT        2'h1
`define MMD_TX_DATA        2'h2
`define MMD_TX_STATUS_PC   4'hC

`endif

// ---- verilog/mmd_pkg.sv ----
package mmd_pkg;

    typedef enum logic [1:0] {
        MMD_PRM_BEND_RANGE = 2'b00,
        MMD_PRM_DET_AMOUNT = 2'b01,
        MMD_PRM_DET_TYPE   = 2'b10,
        MMD_PRM_SEMITONE   = 2'b11
    } mmd_prm_id_t;

    typedef enum logic [0:0] {
        MMD_ST_PARSE = 1'b0,
        MMD_ST_WRITE = 1'b1
    } mmd_state_t;

    typedef struct packed {
        logic [3:0]  slot;
        logic [1:0]  layer;
        mmd_prm_id_t id;
        logic [6:0]  val;
    } mmd_prm_t;

    typedef struct packed {
        logic [3:0] kind;
        logic [3:0] chan;
        logic [6:0] d1;
        logic [6:0] d2;
    } mmd_ev_t;

    typedef struct packed {
        logic [3:0] chan;
        logic [2:0] bank;
        logic [6:0] num;
        logic       gm;
    } mmd_pc_t;

endpackage : mmd_pkg

// ---- verilog/mmd_fifo.sv ----
`timescale 1ns/10ps
module mmd_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);
    localparam logic [CW-1:0] FULL = CW'(D);
    localparam logic [AW-1:0] LAST = AW'(D - 1);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        nxt = (p == LAST) ? '0 : AW'(p + 1'b1);
    endfunction : nxt

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
    assign cnt_d     = push & ~pop ? CW'(cnt_q + 1'b1) :
                       pop & ~push ? CW'(cnt_q - 1'b1) : cnt_q;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q     <= '0;
            rd_q     <= '0;
            cnt_q    <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) wr_q <= nxt(wr_q);
            if (pop)  rd_q <= nxt(rd_q);
            cnt_q    <= cnt_d;
            in_ready <= (cnt_d != FULL);
        end
    end

endmodule : mmd_fifo

// ---- verilog/mmd_dispatcher.sv ----
`timescale 1ns/10ps
`include "mmd_map.svh"

module mmd_dispatcher #(
    parameter logic [6:0] MODEL_ID = 7'h5A,  // arbitrary value
    parameter int         DEPTH    = `MMD_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    // received byte stream
    input  wire logic                    rx_valid,
    input  wire logic [7:0]              rx_data,
    output logic                         rx_ready,
    // configuration
    input  wire logic                    multi_mode,
    input  wire logic                    gm_enable,
    input  wire logic [2:0]              cur_bank,
    input  wire logic [3:0]              sel_chan,
    input  wire logic                    pc_tx_en,
    input  wire logic                    edited_clr,
    // program parameter writes
    output logic                         prm_valid,
    output mmd_pkg::mmd_prm_t            prm_data,
    input  wire logic                    prm_ready,
    // channel events to the engine
    output logic                         ev_valid,
    output mmd_pkg::mmd_ev_t             ev_data,
    output logic                         pc_valid,
    output mmd_pkg::mmd_pc_t             pc_data,
    output logic                         notes_off,
    // exclusive payload
    output logic                         sx_valid,
    output logic [7:0]                   sx_byte,
    output logic                         sx_last,
    // program change transmit
    input  wire logic                    tx_req,
    input  wire logic [3:0]              tx_chan,
    input  wire logic [6:0]              tx_num,
    output logic                         tx_valid,
    output logic [7:0]                   tx_byte,
    input  wire logic                    tx_ready,
    // status
    output logic                         edited
);
    mmd_pkg::mmd_state_t st_q;
    logic [7:0]          run_q;
    logic [6:0]          d1_q;
    logic                have_d1_q;
    logic                sx_on_q;
    logic                sx_hdr_q;
    logic                sx_ok_q;
    logic [6:0]          rpn_msb_q [`MMD_CHANNELS];
    logic [6:0]          rpn_lsb_q [`MMD_CHANNELS];
    logic [1:0]          tx_ph_q;
    logic [6:0]          tx_num_q;

    logic                f_valid;
    logic                f_ready;
    logic [7:0]          b;

    mmd_fifo #(
        .W (`MMD_BYTE_W),
        .D (DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   (rx_data),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (b)
    );

    function automatic logic two_data(input logic [3:0] k);
        two_data = (k != `MMD_KIND_PROG) && (k != `MMD_KIND_CHPRESS);
    endfunction : two_data

    function automatic mmd_pkg::mmd_prm_id_t prm_of(input logic [6:0] sel);
        case (sel)
            `MMD_RPN_BEND:   prm_of = mmd_pkg::MMD_PRM_BEND_RANGE;
            `MMD_RPN_FINE:   prm_of = mmd_pkg::MMD_PRM_DET_AMOUNT;
            default:         prm_of = mmd_pkg::MMD_PRM_SEMITONE;
        endcase
    endfunction : prm_of

    // byte classification
    wire       take     = f_valid & f_ready;
    wire       is_stat  = b[7];
    wire       is_rt    = (b >= `MMD_RT_MIN);
    wire [3:0] kind     = run_q[7:4];
    wire [3:0] chan     = run_q[3:0];
    wire       in_voice = run_q[7] & (kind != 4'hF);
    wire       need2    = two_data(kind);
    wire       dat      = take & ~is_stat;
    wire       sx_dat   = dat & sx_on_q;
    wire       ch_dat   = dat & ~sx_on_q & in_voice;
    wire       msg_done = ch_dat & (~need2 | have_d1_q);
    wire [6:0] m_d1     = need2 ? d1_q : b[6:0];
    wire [6:0] m_d2     = need2 ? b[6:0] : `MMD_ZERO7;

    // controller decode of a completed message
    wire       is_cc    = msg_done & (kind == `MMD_KIND_CTRL);
    wire       cc_msb   = is_cc & (m_d1 == `MMD_CC_RPN_MSB);
    wire       cc_lsb   = is_cc & (m_d1 == `MMD_CC_RPN_LSB);
    wire       cc_data  = is_cc & (m_d1 == `MMD_CC_DATA);
    wire       cc_local = is_cc & (m_d1 == `MMD_CC_LOCAL);
    wire       cc_ano   = is_cc & (m_d1 == `MMD_CC_NOTES_OFF) & (m_d2 == `MMD_ZERO7);
    wire       cc_own   = cc_msb | cc_lsb | cc_data | cc_local | cc_ano;
    wire       sel_ok   = (rpn_msb_q[chan] == `MMD_RPN_MSB_VAL) &&
                          (rpn_lsb_q[chan] <= `MMD_RPN_COARSE);
    wire       rpn_gate = multi_mode & gm_enable;
    wire       rpn_go   = cc_data & sel_ok & rpn_gate;
    wire       rt_reset = take & (b == `MMD_RT_RESET);
    wire       is_pc    = msg_done & (kind == `MMD_KIND_PROG);

    // exclusive framing
    wire       sx_begin = take & (b == `MMD_SX_START);
    wire       sx_close = take & (b == `MMD_SX_END) & sx_on_q;
    wire       sx_match = sx_dat & sx_hdr_q & (b[6:0] == MODEL_ID);
    wire       sx_pass  = sx_dat & (sx_ok_q | sx_match);

    // parameter write sequencing
    wire       wr_acc   = prm_valid & prm_ready;
    wire       wr_last  = wr_acc & (prm_data.layer == `MMD_LAST_LAYER);
    wire       to_type  = wr_last & (prm_data.id == mmd_pkg::MMD_PRM_DET_AMOUNT);
    wire       wr_done  = wr_last & ~to_type;

    // parser stalls the fifo while parameter writes are pending
    assign f_ready = (st_q == mmd_pkg::MMD_ST_PARSE);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= mmd_pkg::MMD_ST_PARSE;
        end else begin
            case (st_q)
                mmd_pkg::MMD_ST_PARSE: if (rpn_go) st_q <= mmd_pkg::MMD_ST_WRITE;
                mmd_pkg::MMD_ST_WRITE: if (wr_done) st_q <= mmd_pkg::MMD_ST_PARSE;
                default:               st_q <= mmd_pkg::MMD_ST_PARSE;
            endcase
        end
    end

    // running status and first data byte
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q     <= `MMD_NO_STATUS;
            d1_q      <= `MMD_ZERO7;
            have_d1_q <= 1'b0;
        end else if (take & is_stat & ~is_rt) begin
            run_q     <= (b < `MMD_SX_START) ? b : `MMD_NO_STATUS;
            have_d1_q <= 1'b0;
        end else if (ch_dat) begin
            d1_q      <= b[6:0];
            have_d1_q <= need2 & ~have_d1_q;
        end
    end

    // exclusive state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sx_on_q  <= 1'b0;
            sx_hdr_q <= 1'b0;
            sx_ok_q  <= 1'b0;
        end else if (take & is_stat & ~is_rt) begin
            sx_on_q  <= sx_begin;
            sx_hdr_q <= sx_begin;
            sx_ok_q  <= 1'b0;
        end else if (sx_dat) begin
            sx_hdr_q <= 1'b0;
            sx_ok_q  <= sx_ok_q | sx_match;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sx_valid <= 1'b0;
            sx_byte  <= 8'h00;
            sx_last  <= 1'b0;
        end else begin
            sx_valid <= sx_pass | (sx_close & sx_ok_q);
            sx_last  <= sx_close & sx_ok_q;
            if (sx_pass | sx_close) sx_byte <= b;
        end
    end

    // per-channel parameter selection
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `MMD_CHANNELS; i++) begin
                rpn_msb_q[i] <= `MMD_RPN_NULL;
                rpn_lsb_q[i] <= `MMD_RPN_NULL;
            end
        end else begin
            if (cc_msb) rpn_msb_q[chan] <= m_d2;
            if (cc_lsb) rpn_lsb_q[chan] <= m_d2;
        end
    end

    // parameter writes go only to the engine port; no display refresh path
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prm_valid <= 1'b0;
            prm_data  <= '0;
        end else if (rpn_go) begin
            prm_valid      <= 1'b1;
            prm_data.slot  <= chan;
            prm_data.layer <= 2'h0;
            prm_data.id    <= prm_of(rpn_lsb_q[chan]);
            prm_data.val   <= m_d2;
        end else if (to_type) begin
            prm_data.layer <= 2'h0;
            prm_data.id    <= mmd_pkg::MMD_PRM_DET_TYPE;
            prm_data.val   <= `MMD_DETUNE_NORMAL;
        end else if (wr_done) begin
            prm_valid <= 1'b0;
        end else if (wr_acc) begin
            prm_data.layer <= prm_data.layer + 2'h1;
        end
    end

    // modified indicator; a set in the same cycle beats the clear
    wire ed_set = rpn_go & (chan == sel_chan);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            edited <= 1'b0;
        end else begin
            edited <= ed_set | (edited & ~edited_clr);
        end
    end

    // channel events, program change and notes off
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ev_valid  <= 1'b0;
            ev_data   <= '0;
            notes_off <= 1'b0;
        end else begin
            ev_valid  <= msg_done & ~is_pc & ~(is_cc & cc_own);
            notes_off <= cc_local | cc_ano | rt_reset;
            if (msg_done) begin
                ev_data.kind <= kind;
                ev_data.chan <= chan;
                ev_data.d1   <= m_d1;
                ev_data.d2   <= m_d2;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_valid <= 1'b0;
            pc_data  <= '0;
        end else begin
            pc_valid <= is_pc;
            if (is_pc) begin
                pc_data.chan <= chan;
                pc_data.bank <= cur_bank;
                pc_data.num  <= m_d1;
                pc_data.gm   <= (cur_bank == `MMD_GM_BANK);
            end
        end
    end

    // program change transmit, only when the option is on
    wire tx_start = tx_req & pc_tx_en & (tx_ph_q == `MMD_TX_IDLE);
    wire tx_acc   = tx_valid & tx_ready;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_ph_q  <= `MMD_TX_IDLE;
            tx_valid <= 1'b0;
            tx_byte  <= 8'h00;
            tx_num_q <= `MMD_ZERO7;
        end else if (tx_start) begin
            tx_ph_q  <= `MMD_TX_STAT;
            tx_valid <= 1'b1;
            tx_byte  <= {`MMD_TX_STATUS_PC, tx_chan};
            tx_num_q <= tx_num;
        end else if (tx_acc & (tx_ph_q == `MMD_TX_STAT)) begin
            tx_ph_q  <= `MMD_TX_DATA;
            tx_byte  <= {1'b0, tx_num_q};
        end else if (tx_acc) begin
            tx_ph_q  <= `MMD_TX_IDLE;
            tx_valid <= 1'b0;
        end
    end

endmodule : mmd_dispatcher

// ---- test/mmd_dispatcher_asserts.sv ----
`timescale 1ns/10ps
module mmd_dispatcher_chk (
    // clock and reset
    input wire logic              ref_clk,
    input wire logic              rst_n,
    // configuration
    input wire logic              multi_mode,
    input wire logic              gm_enable,
    input wire logic [3:0]        sel_chan,
    input wire logic              pc_tx_en,
    // parameter writes
    input wire logic              prm_valid,
    input wire mmd_pkg::mmd_prm_t prm_data,
    input wire logic              prm_ready,
    // events
    input wire logic              pc_valid,
    input wire mmd_pkg::mmd_pc_t  pc_data,
    input wire logic              notes_off,
    input wire logic              sx_valid,
    input wire logic [7:0]        sx_byte,
    input wire logic              sx_last,
    // transmit and status
    input wire logic              tx_req,
    input wire logic [3:0]        tx_chan,
    input wire logic              tx_valid,
    input wire logic [7:0]        tx_byte,
    input wire logic              tx_ready,
    input wire logic              edited
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire acc = prm_valid && prm_ready;

    property p_det_type;
        prm_valid && prm_data.id == mmd_pkg::MMD_PRM_DET_TYPE |-> prm_data.val == 7'h00;
    endproperty
    a_det_type: assert property (p_det_type) else $error("detune type not normal");
    property p_step;
        acc && prm_data.layer != 2'h3 |=> prm_valid && prm_data.layer == $past(prm_data.layer)
            + 2'h1 && prm_data.id == $past(prm_data.id) && prm_data.slot == $past(prm_data.slot);
    endproperty
    a_step: assert property (p_step) else $error("layer sequence broken");
    property p_chain;
        acc && prm_data.layer == 2'h3 && prm_data.id == mmd_pkg::MMD_PRM_DET_AMOUNT |=>
            prm_valid && prm_data.id == mmd_pkg::MMD_PRM_DET_TYPE && prm_data.layer == 2'h0;
    endproperty
    a_chain: assert property (p_chain) else $error("detune type writes missing");
    property p_end;
        acc && prm_data.layer == 2'h3 && prm_data.id != mmd_pkg::MMD_PRM_DET_AMOUNT |=> !prm_valid;
    endproperty
    a_end: assert property (p_end) else $error("burst longer than four layers");
    property p_mode;
        $rose(prm_valid) |-> $past(multi_mode) && $past(gm_enable) && prm_data.layer == 2'h0;
    endproperty
    a_mode: assert property (p_mode) else $error("write outside multi gm play");
    property p_edit;
        $rose(edited) |-> prm_valid && prm_data.slot == sel_chan;
    endproperty
    a_edit: assert property (p_edit) else $error("edited set without selected write");
    property p_pc_gm;
        pc_valid |-> pc_data.gm == (pc_data.bank == 3'h3);
    endproperty
    a_pc_gm: assert property (p_pc_gm) else $error("gm map flag wrong");
    property p_sx;
        sx_last |-> sx_valid && sx_byte == 8'hF7;
    endproperty
    a_sx: assert property (p_sx) else $error("exclusive end byte wrong");
    property p_tx_open;
        tx_req && pc_tx_en && !tx_valid && !$past(tx_valid) |=>
            tx_valid && tx_byte == {4'hC, $past(tx_chan)};
    endproperty
    a_tx_open: assert property (p_tx_open) else $error("program send not started");
    property p_tx_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("send byte not held");

    c_burst: cover property (acc && prm_data.id == mmd_pkg::MMD_PRM_DET_TYPE);
    c_pc: cover property (pc_valid && pc_data.gm);
    c_off: cover property (notes_off);
endmodule : mmd_dispatcher_chk

bind mmd_dispatcher mmd_dispatcher_chk chk_u (.ref_clk, .rst_n, .multi_mode, .gm_enable,
    .sel_chan, .pc_tx_en, .prm_valid, .prm_data, .prm_ready, .pc_valid, .pc_data, .notes_off,
    .sx_valid, .sx_byte, .sx_last, .tx_req, .tx_chan, .tx_valid, .tx_byte, .tx_ready, .edited);

// ---- test/mmd_sender.sv ----
`timescale 1ns/10ps
module mmd_sender (
    // clock
    input wire logic ref_clk,
    // byte stream
    output logic       rx_valid,
    output logic [7:0] rx_data,
    input wire logic   rx_ready
);
    logic slow = 1'b0;
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h55;
    end
    // bytes held until taken; released data shows the inverse
    task automatic send(input logic [7:0] m[$]);
        foreach (m[i]) begin
            @(negedge ref_clk);
            rx_valid = 1'b1;
            rx_data  = m[i];
            do @(posedge ref_clk); while (rx_ready !== 1'b1);
            if (slow) begin
                @(negedge ref_clk);
                rx_valid = 1'b0;
                rx_data  = ~m[i];
            end
        end
        @(negedge ref_clk);
        if (rx_valid) rx_data = ~rx_data;
        rx_valid = 1'b0;
    endtask : send
endmodule : mmd_sender

// ---- test/mmd_dispatcher_tb.sv ----
`timescale 1ns/10ps
module mmd_dispatcher_tb;
    logic ref_clk, rst_n, rx_valid, rx_ready, multi_mode, gm_enable, pc_tx_en, edited_clr;
    logic prm_valid, prm_ready, ev_valid, pc_valid, notes_off, sx_valid, sx_last, tx_req;
    logic tx_valid, tx_ready, edited;
    logic [7:0] rx_data, sx_byte, tx_byte;
    logic [6:0] tx_num;
    logic [3:0] sel_chan, tx_chan;
    logic [2:0] cur_bank;
    mmd_pkg::mmd_prm_t prm_data;
    mmd_pkg::mmd_ev_t  ev_data;
    mmd_pkg::mmd_pc_t  pc_data;
    mmd_pkg::mmd_prm_t wq[$];
    mmd_pkg::mmd_pc_t  pq[$];
    logic [7:0]        sq[$];
    logic [7:0]        tq[$];
    mmd_pkg::mmd_ev_t  eq[$];
    int err_total = 0;
    int n_tests = 0;
    int n_off = 0, n_last = 0;

    mmd_dispatcher dut_u (.ref_clk, .rst_n, .rx_valid, .rx_data, .rx_ready, .multi_mode,
        .gm_enable, .cur_bank, .sel_chan, .pc_tx_en, .edited_clr, .prm_valid, .prm_data,
        .prm_ready, .ev_valid, .ev_data, .pc_valid, .pc_data, .notes_off, .sx_valid, .sx_byte,
        .sx_last, .tx_req, .tx_chan, .tx_num, .tx_valid, .tx_byte, .tx_ready, .edited);
    mmd_sender snd_u (.ref_clk, .rx_valid, .rx_data, .rx_ready);

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (prm_valid && prm_ready) wq.push_back(prm_data);
        if (pc_valid) pq.push_back(pc_data);
        if (sx_valid) sq.push_back(sx_byte);
        if (tx_valid && tx_ready) tq.push_back(tx_byte);
        if (notes_off) n_off++;
        if (sx_last) n_last++;
        if (ev_valid) eq.push_back(ev_data);
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk
    task automatic settle();
        repeat (30) @(negedge ref_clk);
    endtask : settle
    task automatic rpn(input logic [3:0] ch, input logic [6:0] lsb, input logic [6:0] v);
        snd_u.send('{{4'hB, ch}, 8'h65, 8'h00, 8'h64, {1'b0, lsb}, 8'h06, {1'b0, v}});
    endtask : rpn
    task automatic chk_burst(input logic [3:0] ch, input mmd_pkg::mmd_prm_id_t id,
                             input logic [6:0] v, input int b);
        mmd_pkg::mmd_prm_t e;
        for (int i = 0; i < 4; i++) begin
            e = '{ch, 2'(i), id, v};
            chk("prm_write", 16'(e), 16'(wq[b + i]));
        end
    endtask : chk_burst
    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        #100000;
        err_total++;
        conclude();
    end

    initial begin
        {rst_n, multi_mode, gm_enable, pc_tx_en, edited_clr, tx_req, prm_ready} = 7'h00;
        {cur_bank, sel_chan, tx_chan, tx_num, tx_ready} = {3'h3, 4'h3, 4'h4, 7'h55, 1'b0};
        repeat (5) @(negedge ref_clk);
        rst_n = 1'b1;
        // stalled writes hold the parser, so the buffer fills and refuses
        {multi_mode, gm_enable} = 2'h3;
        fork
            snd_u.send('{8'hB3, 8'h65, 8'h00, 8'h64, 8'h00, 8'h06, 8'h0C, 8'hB3, 8'h07,
                         8'h10, 8'h07, 8'h11, 8'h07, 8'h12, 8'h07, 8'h13, 8'h07});
        join_none
        for (int i = 0; i < 200 && rx_ready !== 1'b0; i++) @(negedge ref_clk);
        chk("rx_ready", 16'h0000, 16'(rx_ready));
        prm_ready = 1'b1;
        wait fork;
        settle();
        chk("write_count", 16'h0004, 16'(wq.size()));
        chk_burst(4'h3, mmd_pkg::MMD_PRM_BEND_RANGE, 7'h0C, 0);
        chk("edited", 16'h0001, 16'(edited));
        chk("ev_count", 32'h4, 32'(eq.size()));
        foreach (eq[i]) chk("ev_data", 32'({4'hB, 4'h3, 7'h07, 7'(16 + i)}), 32'(eq[i]));
        $display("test bend range done");
        edited_clr = 1'b1;
        @(negedge ref_clk);
        edited_clr = 1'b0;
        wq.delete();
        snd_u.slow = 1'b1;
        rpn(4'h5, 7'h01, 7'h40);
        settle();
        chk("write_count", 16'h0008, 16'(wq.size()));
        chk_burst(4'h5, mmd_pkg::MMD_PRM_DET_AMOUNT, 7'h40, 0);
        chk_burst(4'h5, mmd_pkg::MMD_PRM_DET_TYPE, 7'h00, 4);
        chk("edited", 16'h0000, 16'(edited));
        wq.delete();
        snd_u.slow = 1'b0;
        rpn(4'hF, 7'h02, 7'h7F);
        settle();
        chk("write_count", 16'h0004, 16'(wq.size()));
        chk_burst(4'hF, mmd_pkg::MMD_PRM_SEMITONE, 7'h7F, 0);
        $display("test detune and semitone done");
        wq.delete();
        for (int i = 0; i < 3; i++) begin
            multi_mode = (i != 0);
            gm_enable = (i != 1);
            rpn(4'h0, (i == 2) ? 7'h03 : 7'h00, 7'h22);
            // let the data entry reach the parser before the mode moves
            settle();
        end
        snd_u.send('{8'hB0, 8'h65, 8'h7F, 8'h64, 8'h7F, 8'h06, 8'h22});
        settle();
        chk("write_count", 16'h0000, 16'(wq.size()));
        $display("test ignored parameters done");
        snd_u.send('{8'hC2, 8'h05});
        settle();
        cur_bank = 3'h1;
        snd_u.send('{8'hC2, 8'h06});
        settle();
        chk("pc_count", 16'h0002, 16'(pq.size()));
        chk("pc_gm", 16'(mmd_pkg::mmd_pc_t'({4'h2, 3'h3, 7'h05, 1'b1})), 16'(pq[0]));
        chk("pc_other", 16'(mmd_pkg::mmd_pc_t'({4'h2, 3'h1, 7'h06, 1'b0})), 16'(pq[1]));
        snd_u.send('{8'hB0, 8'h7B, 8'h00, 8'h7A, 8'h7F, 8'hFF, 8'hB0, 8'h7B, 8'h05,
                     8'hD1, 8'h20});
        settle();
        chk("notes_off_count", 16'h0003, 16'(n_off));
        chk("ev_count", 32'h6, 32'(eq.size()));
        chk("ev_data", 32'({4'hB, 4'h0, 7'h7B, 7'h05}), 32'(eq[4]));
        chk("ev_data", 32'({4'hD, 4'h1, 7'h20, 7'h00}), 32'(eq[5]));
        snd_u.send('{8'hF0, 8'h5A, 8'h01, 8'h02, 8'hF7, 8'hF0, 8'h11, 8'h01, 8'hF7});
        settle();
        chk("sx_count", 16'h0004, 16'(sq.size()));
        foreach (sq[i]) chk("sx_byte", 8'(32'h5A0102F7 >> (24 - 8 * i)), 32'(sq[i]));
        chk("sx_last_count", 32'h1, 32'(n_last));
        $display("test program, notes off, exclusive done");
        pc_tx_en = 1'b1;
        tx_req = 1'b1;
        @(negedge ref_clk);
        tx_req = 1'b0;
        repeat (3) @(negedge ref_clk);
        tx_ready = 1'b1;
        settle();
        pc_tx_en = 1'b0;
        tx_req = 1'b1;
        @(negedge ref_clk);
        tx_req = 1'b0;
        settle();
        chk("tx_count", 16'h0002, 16'(tq.size()));
        chk("tx_status", 16'h00C4, 16'(tq[0]));
        chk("tx_number", 16'h0055, 16'(tq[1]));
        $display("test program send done");
        conclude();
    end
endmodule : mmd_dispatcher_tb
